// ### verilog/pdio_pkg.sv
`default_nettype none
package pdio_pkg;
    // Bus geometry
    localparam int ADDR_W = 6;
    localparam int DATA_W = 32;
    localparam int BE_W = 4;

    // Port geometry
    localparam int GROUP_W = 8;
    localparam int NUM_GROUPS = 3;
    localparam int BIDIR_W = 24;
    localparam int WORD_W = 16;
    localparam int NUM_IRQ = 4;
    localparam int IRQ_LSB = 16;

    // Register byte offsets
    localparam logic [5:0] OFF_RUN = 6'h00;
    localparam logic [5:0] OFF_DIR = 6'h04;
    localparam logic [5:0] OFF_BIDIR = 6'h08;
    localparam logic [5:0] OFF_OWORD = 6'h0c;
    localparam logic [5:0] OFF_IWORD = 6'h10;
    localparam logic [5:0] OFF_IRQ_POL = 6'h14;
    localparam logic [5:0] OFF_IRQ_STAT = 6'h18;
    localparam logic [5:0] OFF_IRQ_CLR = 6'h1c;
    localparam logic [5:0] OFF_IRQ_EN = 6'h20;

    // Field positions
    localparam int RUN_BIT = 0;

    // Reset values
    localparam logic RST_RUN = 1'h0;
    localparam logic [2:0] RST_DIR = 3'h0;
    localparam logic [23:0] RST_LATCH = 24'h000000;
    localparam logic [15:0] RST_OWORD = 16'h0000;
    localparam logic [3:0] RST_IRQ_POL = 4'h0;
    localparam logic [3:0] RST_IRQ_EN = 4'h0;
    localparam logic [3:0] RST_IRQ_STAT = 4'h0;

    // One bus request as seen by the slave
    typedef struct packed {
        logic read;
        logic write;
        logic [5:0] address;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } pdio_bus_req_t;

    // Interrupt set-up handed to the interrupt unit
    typedef struct packed {
        logic [3:0] pol;
        logic [3:0] en;
    } pdio_irq_cfg_t;
endpackage : pdio_pkg
`default_nettype wire

// ### verilog/pdio_sync.sv
`timescale 1ns/10ps
`default_nettype none
module pdio_sync #(
    parameter int W = 8
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;

    // Two stages; only the second stage is ever read
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            meta_r <= '0;
            sync_r <= '0;
        end
        else
        begin
            meta_r <= async_in;
            sync_r <= meta_r;
        end
    end

    assign sync_out = sync_r;
endmodule : pdio_sync
`default_nettype wire

// ### verilog/pdio_irq.sv
`timescale 1ns/10ps
`default_nettype none
module pdio_irq (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [3:0] src,
    input wire logic run,
    input wire pdio_pkg::pdio_irq_cfg_t cfg,
    input wire logic [3:0] clr,
    output logic [3:0] status,
    output logic irq
);
    logic [3:0] level;
    logic [3:0] status_r;
    logic [3:0] status_nxt;
    logic irq_r;
    logic irq_nxt;

    // Polarity first, then an active-high level; a live level beats a clear
    always_comb
    begin
        level = (src ^ cfg.pol) & {4{run}};
        status_nxt = level | (status_r & ~clr);
        irq_nxt = |(status_nxt & cfg.en);
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            status_r <= pdio_pkg::RST_IRQ_STAT;
            irq_r <= 1'b0;
        end
        else
        begin
            status_r <= status_nxt;
            irq_r <= irq_nxt;
        end
    end

    assign status = status_r;
    assign irq = irq_r;

    property p_level_sets;
        @(posedge ref_clk) disable iff (reset)
        (run && ((src[0] ^ cfg.pol[0]) == 1'b1)) |=> status_r[0];
    endproperty
    a_level_sets: assert property (p_level_sets)
        else $error("active source level did not set status");

    property p_irq_follows;
        @(posedge ref_clk) disable iff (reset)
        ##1 (irq_r == |(status_r & $past(cfg.en)));
    endproperty
    a_irq_follows: assert property (p_irq_follows)
        else $error("interrupt output disagrees with enabled status");

    property p_sticky;
        @(posedge ref_clk) disable iff (reset)
        (status_r[1] && !clr[1]) |=> status_r[1];
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("status bit dropped without a clear");
endmodule : pdio_irq
`default_nettype wire

// ### verilog/pdio_top.sv
`timescale 1ns/10ps
`default_nettype none
module pdio_top #(
    parameter bit FULL_BUILD = 1'b1
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [23:0] bidir_connector_in,
    output logic [23:0] bidir_connector_out,
    output logic [23:0] bidir_connector_oe_n,
    input wire logic [15:0] input_word_port,
    output logic [15:0] output_word_connector,
    output logic irq
);
    pdio_pkg::pdio_bus_req_t req;
    logic take;
    logic fire_wr;
    logic [23:0] bidir_sync;
    logic [15:0] iword_sync;
    logic [23:0] bidir_view;
    logic [15:0] iword_view;
    logic [3:0] irq_status;
    logic [3:0] irq_clr;
    pdio_pkg::pdio_irq_cfg_t irq_cfg;

    logic run_r;
    logic run_nxt;
    logic [2:0] dir_r;
    logic [2:0] dir_nxt;
    logic [23:0] latch_r;
    logic [23:0] latch_nxt;
    logic [15:0] oword_r;
    logic [15:0] oword_nxt;
    logic [15:0] opin_r;
    logic [15:0] opin_nxt;
    logic [23:0] oe_n_r;
    logic [23:0] oe_n_nxt;
    logic [3:0] pol_r;
    logic [3:0] pol_nxt;
    logic [3:0] ien_r;
    logic [3:0] ien_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic wait_r;
    logic wait_nxt;

    // Word decode shared by the write and read paths
    function automatic logic hit(input logic [5:0] addr, input logic [5:0] off);
        hit = (addr[5:2] == off[5:2]);
    endfunction : hit

    // Bundle the bus request
    assign req.read = avs_read;
    assign req.write = avs_write;
    assign req.address = avs_address;
    assign req.writedata = avs_writedata;
    assign req.byteenable = avs_byteenable;
    assign take = (req.read || req.write) && wait_r;
    assign fire_wr = req.write && !wait_r;

    // Field pins are asynchronous to ref_clk
    pdio_sync #(
        .W(pdio_pkg::BIDIR_W)
    ) u_sync_bidir (
        .ref_clk(ref_clk),
        .reset(reset),
        .async_in(bidir_connector_in),
        .sync_out(bidir_sync)
    );

    pdio_sync #(
        .W(pdio_pkg::WORD_W)
    ) u_sync_iword (
        .ref_clk(ref_clk),
        .reset(reset),
        .async_in(input_word_port),
        .sync_out(iword_sync)
    );

    // Per-group read view: zero while stopped, else latch when output, pins when input
    genvar g;
    generate
        for (g = 0; g < pdio_pkg::NUM_GROUPS; g++)
        begin : g_grp
            assign bidir_view[g*8 +: 8] = !run_r ? 8'h00 :
                dir_r[g] ? latch_r[g*8 +: 8] : bidir_sync[g*8 +: 8];
        end
        if (FULL_BUILD)
        begin : g_full
            assign iword_view = run_r ? iword_sync : 16'h0000;
        end
        else
        begin : g_reduced
            assign iword_view = 16'h0000;
        end
    endgenerate

    // Register writes; data latches stay frozen while the port is stopped
    always_comb
    begin
        run_nxt = run_r;
        dir_nxt = dir_r;
        latch_nxt = latch_r;
        oword_nxt = oword_r;
        pol_nxt = pol_r;
        ien_nxt = ien_r;
        irq_clr = 4'h0;
        if (fire_wr)
        begin
            if (hit(req.address, pdio_pkg::OFF_RUN) && req.byteenable[0])
            begin
                run_nxt = req.writedata[pdio_pkg::RUN_BIT];
            end
            if (hit(req.address, pdio_pkg::OFF_DIR) && req.byteenable[0])
            begin
                dir_nxt = req.writedata[2:0];
            end
            if (hit(req.address, pdio_pkg::OFF_BIDIR) && run_r)
            begin
                for (int i = 0; i < pdio_pkg::NUM_GROUPS; i++)
                begin
                    if (req.byteenable[i])
                    begin
                        latch_nxt[i*8 +: 8] = req.writedata[i*8 +: 8];
                    end
                end
            end
            if (hit(req.address, pdio_pkg::OFF_OWORD) && run_r && FULL_BUILD)
            begin
                for (int i = 0; i < 2; i++)
                begin
                    if (req.byteenable[i])
                    begin
                        oword_nxt[i*8 +: 8] = req.writedata[i*8 +: 8];
                    end
                end
            end
            if (hit(req.address, pdio_pkg::OFF_IRQ_POL) && req.byteenable[0])
            begin
                pol_nxt = req.writedata[3:0];
            end
            if (hit(req.address, pdio_pkg::OFF_IRQ_EN) && req.byteenable[0])
            begin
                ien_nxt = req.writedata[3:0];
            end
            if (hit(req.address, pdio_pkg::OFF_IRQ_CLR) && req.byteenable[0])
            begin
                irq_clr = req.writedata[3:0];
            end
        end
    end

    // Pin drivers; one flop of lag keeps every output registered
    always_comb
    begin
        for (int i = 0; i < pdio_pkg::NUM_GROUPS; i++)
        begin
            oe_n_nxt[i*8 +: 8] = {8{!(run_r && dir_r[i])}};
        end
        opin_nxt = (run_r && FULL_BUILD) ? oword_r : 16'h0000;
    end

    // Read mux and one-wait-state handshake; unmapped reads give zero
    always_comb
    begin
        rdata_nxt = rdata_r;
        wait_nxt = !take;
        if (take && req.read)
        begin
            rdata_nxt = 32'h00000000;
            if (hit(req.address, pdio_pkg::OFF_RUN))
            begin
                rdata_nxt[0] = run_r;
            end
            if (hit(req.address, pdio_pkg::OFF_DIR))
            begin
                rdata_nxt[2:0] = dir_r;
            end
            if (hit(req.address, pdio_pkg::OFF_BIDIR))
            begin
                rdata_nxt[23:0] = bidir_view;
            end
            if (hit(req.address, pdio_pkg::OFF_OWORD))
            begin
                rdata_nxt[15:0] = oword_r;
            end
            if (hit(req.address, pdio_pkg::OFF_IWORD))
            begin
                rdata_nxt[15:0] = iword_view;
            end
            if (hit(req.address, pdio_pkg::OFF_IRQ_POL))
            begin
                rdata_nxt[3:0] = pol_r;
            end
            if (hit(req.address, pdio_pkg::OFF_IRQ_STAT))
            begin
                rdata_nxt[3:0] = irq_status;
            end
            if (hit(req.address, pdio_pkg::OFF_IRQ_EN))
            begin
                rdata_nxt[3:0] = ien_r;
            end
        end
    end

    // State registers; all groups come up stopped and as inputs
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            run_r <= pdio_pkg::RST_RUN;
            dir_r <= pdio_pkg::RST_DIR;
            latch_r <= pdio_pkg::RST_LATCH;
            oword_r <= pdio_pkg::RST_OWORD;
            opin_r <= pdio_pkg::RST_OWORD;
            oe_n_r <= 24'hffffff;
            pol_r <= pdio_pkg::RST_IRQ_POL;
            ien_r <= pdio_pkg::RST_IRQ_EN;
            rdata_r <= 32'h00000000;
            wait_r <= 1'b1;
        end
        else
        begin
            run_r <= run_nxt;
            dir_r <= dir_nxt;
            latch_r <= latch_nxt;
            oword_r <= oword_nxt;
            opin_r <= opin_nxt;
            oe_n_r <= oe_n_nxt;
            pol_r <= pol_nxt;
            ien_r <= ien_nxt;
            rdata_r <= rdata_nxt;
            wait_r <= wait_nxt;
        end
    end

    // Group C low nibble feeds the interrupt unit
    assign irq_cfg.pol = pol_r;
    assign irq_cfg.en = ien_r;

    pdio_irq u_irq (
        .ref_clk(ref_clk),
        .reset(reset),
        .src(bidir_sync[pdio_pkg::IRQ_LSB +: pdio_pkg::NUM_IRQ]),
        .run(run_r),
        .cfg(irq_cfg),
        .clr(irq_clr),
        .status(irq_status),
        .irq(irq)
    );

    assign avs_readdata = rdata_r;
    assign avs_waitrequest = wait_r;
    assign bidir_connector_out = latch_r;
    assign bidir_connector_oe_n = oe_n_r;
    assign output_word_connector = opin_r;

    property p_dir_reset;
        @(posedge ref_clk) reset |=> (dir_r == 3'h0) && (oe_n_r == 24'hffffff);
    endproperty
    a_dir_reset: assert property (p_dir_reset)
        else $error("groups not input after reset");

    property p_run_reset;
        @(posedge ref_clk) reset |=> !run_r ##1 (output_word_connector == 16'h0000);
    endproperty
    a_run_reset: assert property (p_run_reset)
        else $error("port not stopped after reset");

    property p_oword_reset;
        @(posedge ref_clk) reset |=> (oword_r == 16'h0000);
    endproperty
    a_oword_reset: assert property (p_oword_reset)
        else $error("output word latch not cleared");

    property p_dir_write;
        @(posedge ref_clk) disable iff (reset)
        (fire_wr && hit(req.address, pdio_pkg::OFF_DIR) && req.byteenable[0])
        |=> (dir_r == $past(req.writedata[2:0]));
    endproperty
    a_dir_write: assert property (p_dir_write)
        else $error("direction write not applied");

    property p_drive;
        @(posedge ref_clk) disable iff (reset)
        ##1 (oe_n_r[23:16] == {8{!($past(run_r) && $past(dir_r[2]))}});
    endproperty
    a_drive: assert property (p_drive)
        else $error("group C driven out of turn");

    property p_read_latch;
        @(posedge ref_clk) disable iff (reset)
        (take && req.read && hit(req.address, pdio_pkg::OFF_BIDIR) && run_r && dir_r[0])
        |=> !avs_waitrequest && (avs_readdata[7:0] == $past(latch_r[7:0]));
    endproperty
    a_read_latch: assert property (p_read_latch)
        else $error("output group did not read back its latch");

    property p_reduced;
        @(posedge ref_clk) disable iff (reset)
        !FULL_BUILD |-> (output_word_connector == 16'h0000);
    endproperty
    a_reduced: assert property (p_reduced)
        else $error("reduced build drives output word");

    property p_full_in;
        @(posedge ref_clk) disable iff (reset)
        (FULL_BUILD && take && req.read && hit(req.address, pdio_pkg::OFF_IWORD) && run_r)
        |=> (avs_readdata[15:0] == $past(iword_sync));
    endproperty
    a_full_in: assert property (p_full_in)
        else $error("input word read mismatch");
endmodule : pdio_top
`default_nettype wire

// ### bench/pdio_field_model.sv
`timescale 1ns/10ps
`default_nettype none
module pdio_field_model (
    input wire logic [23:0] drv_out,
    input wire logic [23:0] drv_oe_n,
    input wire logic [23:0] ext_level,
    output logic [23:0] pins
);
    // Wire level: device wins where it drives, field wiring elsewhere
    always_comb
    begin
        pins = (drv_oe_n & ext_level) | (~drv_oe_n & drv_out);
    end
endmodule : pdio_field_model
`default_nettype wire

// ### bench/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic ref_clk;
    logic reset;
    logic [5:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [3:0] avs_byteenable;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [23:0] pins;
    logic [23:0] ext;
    logic [23:0] bd_out;
    logic [23:0] bd_oe_n;
    logic [15:0] iword;
    logic [15:0] oword;
    logic [15:0] oword_red;
    logic irq;
    int error_cnt;
    int total_checks;
    logic [31:0] seed;
    // Bench model of the register state
    logic run_m;
    logic [2:0] dir_m;
    logic [23:0] latch_m;
    logic [15:0] oword_m;

    // Free-running 100 MHz clock
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    pdio_top #(.FULL_BUILD(1'b1)) dut (
        .ref_clk(ref_clk), .reset(reset), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .bidir_connector_in(pins),
        .bidir_connector_out(bd_out), .bidir_connector_oe_n(bd_oe_n),
        .input_word_port(iword), .output_word_connector(oword), .irq(irq)
    );

    // Reduced build shadows the same bus; only its word output is watched
    pdio_top #(.FULL_BUILD(1'b0)) dut_red (
        .ref_clk(ref_clk), .reset(reset), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(),
        .avs_waitrequest(), .bidir_connector_in(pins),
        .bidir_connector_out(), .bidir_connector_oe_n(),
        .input_word_port(iword), .output_word_connector(oword_red), .irq()
    );

    pdio_field_model field (
        .drv_out(bd_out), .drv_oe_n(bd_oe_n), .ext_level(ext), .pins(pins)
    );

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    // Expected wire level per group
    function automatic logic [23:0] wire_exp();
        logic [23:0] v;
        for (int g = 0; g < 3; g++)
            v[g*8 +: 8] = (run_m && dir_m[g]) ? latch_m[g*8 +: 8] : ext[g*8 +: 8];
        return v;
    endfunction : wire_exp

    function automatic logic [23:0] oe_exp();
        logic [23:0] v;
        for (int g = 0; g < 3; g++)
            v[g*8 +: 8] = (run_m && dir_m[g]) ? 8'h00 : 8'hff;
        return v;
    endfunction : oe_exp

    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : test_done

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    // One bus access; request held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 50);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (n >= 50)
        begin
            error_cnt++;
            test_done();
        end
    endtask : bus

    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
        case (a)
            pdio_pkg::OFF_RUN: run_m = d[0];
            pdio_pkg::OFF_DIR: dir_m = d[2:0];
            pdio_pkg::OFF_BIDIR: if (run_m) latch_m = d[23:0];
            pdio_pkg::OFF_OWORD: if (run_m) oword_m = d[15:0];
            default: ;
        endcase
    endtask : wr

    task automatic rdchk(input string n, input logic [5:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(n, e, q);
    endtask : rdchk

    task automatic pin_chk();
        repeat (3) @(posedge ref_clk);
        chk("oe_n", {8'h00, oe_exp()}, {8'h00, bd_oe_n});
        chk("pins", {8'h00, wire_exp()}, {8'h00, pins});
        rdchk("bidir view", pdio_pkg::OFF_BIDIR, {8'h00, run_m ? wire_exp() : 24'h0});
    endtask : pin_chk

    // Main sequence
    initial
    begin
        seed = 32'hebe85507;
        error_cnt = 0;
        total_checks = 0;
        reset = 1'b1;
        avs_address = 6'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hf;
        ext = 24'h0;
        iword = 16'h0;
        run_m = 1'b0;
        dir_m = 3'h0;
        latch_m = 24'h0;
        oword_m = 16'h0;
        repeat (12) @(posedge ref_clk);
        reset <= 1'b0;
        ext <= 24'(xs()) & 24'hf0ffff;
        iword <= 16'(xs());
        // Every register, plus one unmapped place, reads zero out of reset
        for (int a = 0; a < 40; a += 4)
            rdchk("reset reg", 6'(a), 32'h0);
        chk("oe_n reset", 32'h00ffffff, {8'h00, bd_oe_n});
        chk("oword reset", 32'h0, {16'h0, oword});
        wr(pdio_pkg::OFF_BIDIR, xs());
        wr(pdio_pkg::OFF_OWORD, xs());
        rdchk("oword stopped", pdio_pkg::OFF_OWORD, {16'h0, oword_m});
        $display("test reset done");
        // Every direction pattern, fresh latch and field values each time
        wr(pdio_pkg::OFF_RUN, 32'h1);
        for (int d = 0; d < 8; d++)
        begin
            ext <= 24'(xs()) & 24'hf0ffff;
            wr(pdio_pkg::OFF_DIR, 32'(d));
            wr(pdio_pkg::OFF_BIDIR, xs());
            pin_chk();
            rdchk("bidir", pdio_pkg::OFF_BIDIR, {8'h00, wire_exp()});
            chk("latch out", {8'h00, latch_m}, {8'h00, bd_out});
        end
        $display("test groups done");
        // Word ports, the output word in both builds, then stop and restart
        iword <= 16'(xs());
        wr(pdio_pkg::OFF_OWORD, xs());
        repeat (3) @(posedge ref_clk);
        rdchk("iword", pdio_pkg::OFF_IWORD, {16'h0, iword});
        chk("oword", {16'h0, oword_m}, {16'h0, oword});
        chk("oword reduced", 32'h0, {16'h0, oword_red});
        wr(pdio_pkg::OFF_RUN, 32'h0);
        wr(pdio_pkg::OFF_OWORD, xs());
        pin_chk();
        chk("oword stopped", 32'h0, {16'h0, oword});
        rdchk("iword stopped", pdio_pkg::OFF_IWORD, 32'h0);
        wr(pdio_pkg::OFF_RUN, 32'h1);
        repeat (3) @(posedge ref_clk);
        chk("oword restart", {16'h0, oword_m}, {16'h0, oword});
        $display("test words done");
        // Interrupt sources: raise, mask, clear, invert
        wr(pdio_pkg::OFF_DIR, 32'h0);
        ext <= ext & 24'hf0ffff;
        // Group C drive earlier left stale sticky bits; settle pins, then clear
        repeat (4) @(posedge ref_clk);
        wr(pdio_pkg::OFF_IRQ_CLR, 32'hf);
        rdchk("status idle", pdio_pkg::OFF_IRQ_STAT, 32'h0);
        wr(pdio_pkg::OFF_IRQ_EN, 32'hf);
        rdchk("irq en", pdio_pkg::OFF_IRQ_EN, 32'hf);
        for (int i = 0; i < 4; i++)
        begin
            ext[16+i] <= 1'b1;
            repeat (6) @(posedge ref_clk);
            rdchk("status", pdio_pkg::OFF_IRQ_STAT, 32'h1 << i);
            chk("irq", 32'h1, {31'h0, irq});
            wr(pdio_pkg::OFF_IRQ_EN, 32'h0);
            repeat (3) @(posedge ref_clk);
            chk("irq masked", 32'h0, {31'h0, irq});
            wr(pdio_pkg::OFF_IRQ_EN, 32'hf);
            wr(pdio_pkg::OFF_IRQ_CLR, 32'h1 << i);
            rdchk("status level", pdio_pkg::OFF_IRQ_STAT, 32'h1 << i);
            ext[16+i] <= 1'b0;
            repeat (6) @(posedge ref_clk);
            wr(pdio_pkg::OFF_IRQ_CLR, 32'h1 << i);
            rdchk("status clr", pdio_pkg::OFF_IRQ_STAT, 32'h0);
            chk("irq clr", 32'h0, {31'h0, irq});
            wr(pdio_pkg::OFF_IRQ_POL, 32'h1 << i);
            repeat (6) @(posedge ref_clk);
            rdchk("pol", pdio_pkg::OFF_IRQ_POL, 32'h1 << i);
            rdchk("status inv", pdio_pkg::OFF_IRQ_STAT, 32'h1 << i);
            wr(pdio_pkg::OFF_IRQ_POL, 32'h0);
            wr(pdio_pkg::OFF_IRQ_CLR, 32'hf);
            rdchk("status end", pdio_pkg::OFF_IRQ_STAT, 32'h0);
        end
        $display("test interrupts done");
        test_done();
    end
endmodule : tb
`default_nettype wire
